// file: rtl/smsp_pkg.sv
// Shared constants, types and address decoding for the serial memory
// programmer link. Both ends rely on these names; the synchroniser uses none of them.
package smsp_pkg;

    // ****************************************************************
    // Opcodes and fixed byte values
    // ****************************************************************
    localparam logic [7:0] FETCH_OPCODE = 8'h03;
    localparam logic [7:0] WRITE_ARM_OPCODE = 8'h06;
    localparam logic [7:0] PROGRAM_OPCODE = 8'h02;
    localparam logic [7:0] FILLER_BYTE = 8'h00;
    localparam logic [7:0] IDLE_REPLY = 8'h00;
    localparam int MAX_WRITE = 128;

    // ****************************************************************
    // Memory windows
    // ****************************************************************
    localparam logic [23:0] EE_LO = 24'h004000;
    localparam logic [23:0] EE_HI = 24'h0047ff;
    localparam logic [23:0] FLASH_LO = 24'h008000;
    localparam logic [23:0] FLASH_HI = 24'h027fff;
    localparam logic [23:0] EE_SIZE = EE_HI - EE_LO + 24'h000001;
    localparam logic [23:0] FLASH_SIZE = FLASH_HI - FLASH_LO + 24'h000001;
    localparam int MEM_BYTES = int'(EE_SIZE + FLASH_SIZE);
    localparam int IDX_W = 18;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SYS_HZ = 25_000_000;
    localparam int SCK_HZ = 4_000_000;
    localparam int SCK_HALF_CYC = (SYS_HZ + 2 * SCK_HZ - 1) / (2 * SCK_HZ);
    localparam int GAP_CYC = 200;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ****************************************************************
    // Types and decoding
    // ****************************************************************
    typedef enum {PH_OPC, PH_A2, PH_A1, PH_A0, PH_DATA} smsp_phase_t;
    typedef enum {CMD_NONE, CMD_FETCH, CMD_PROGRAM} smsp_cmd_t;

    function automatic logic in_range(input logic [23:0] a);
        in_range = (a >= EE_LO && a <= EE_HI) || (a >= FLASH_LO && a <= FLASH_HI);
    endfunction

    function automatic logic [IDX_W-1:0] mem_index(input logic [23:0] a);
        logic [23:0] off;
        off = (a <= EE_HI) ? a - EE_LO : a - FLASH_LO + EE_SIZE;
        mem_index = off[IDX_W-1:0];
    endfunction

endpackage

// file: rtl/smsp_link_if.sv
// Four-wire serial link between the programming master and the memory
// slave. The master makes the clock and the select; nothing is shared.
`timescale 1ns/10ps
interface smsp_link_if;
    logic sck;
    logic slave_select_n;
    logic mosi;
    logic miso;

    modport dev (
        input sck,
        input slave_select_n,
        input mosi,
        output miso
    );

    modport host (
        output sck,
        output slave_select_n,
        output mosi,
        input miso
    );
endinterface

// file: rtl/smsp_sync.sv
// Two-flop level synchroniser, one bit lane per input bit.
// Assumes a synchronous active-high reset in the destination domain.
`timescale 1ns/10ps
module smsp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [W-1:0] D,
    output logic [W-1:0] Q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge CLK) begin
        if (RST) begin
            meta_r <= INIT;
            Q <= INIT;
        end else begin
            meta_r <= D;
            Q <= meta_r;
        end
    end
endmodule

// file: rtl/smsp_slave.sv
// Memory slave end: decodes opcodes on the link clock, serves reads from
// its own memory and commits buffered writes on its system clock.
// Assumes the master stops the link clock while select is high.
`timescale 1ns/10ps
module smsp_slave #(
    parameter int WBUF_DEPTH = smsp_pkg::MAX_WRITE
) (
    smsp_link_if.dev LINK,
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [23:0] PEEK_ADDR,
    output logic [7:0] PEEK_DATA,
    output logic BUSY,
    output logic PROG_DONE,
    output logic WRITE_ARMED
);
    localparam int CNT_W = $clog2(WBUF_DEPTH + 1);
    localparam int BI_W = $clog2(WBUF_DEPTH);
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(WBUF_DEPTH);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0] mem [smsp_pkg::MEM_BYTES];
    logic [7:0] wbuf [WBUF_DEPTH];

    function automatic logic [7:0] mem_read(input logic [23:0] a);
        mem_read = smsp_pkg::in_range(a) ? mem[smsp_pkg::mem_index(a)]
                                         : smsp_pkg::IDLE_REPLY;
    endfunction

    // ****************************************************************
    // Link domain state
    // ****************************************************************
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [6:0] shreg;
        smsp_pkg::smsp_phase_t phase;
        smsp_pkg::smsp_cmd_t cmd;
        logic [23:0] ptr;
        logic [7:0] tx;
    } smsp_frame_t;

    typedef struct packed {
        logic armed;
        logic wr_go;
        logic [23:0] wr_addr;
        logic [CNT_W-1:0] wr_cnt;
    } smsp_keep_t;

    localparam smsp_frame_t FRAME_RST = '{
        bit_cnt: 3'h0, shreg: 7'h00, phase: smsp_pkg::PH_OPC,
        cmd: smsp_pkg::CMD_NONE, ptr: 24'h000000, tx: 8'h00};
    localparam smsp_keep_t KEEP_RST = '{
        armed: 1'b0, wr_go: 1'b0, wr_addr: 24'h000000, wr_cnt: '0};

    smsp_frame_t fr_r;
    smsp_frame_t fr_nxt;
    smsp_keep_t kp_r;
    smsp_keep_t kp_nxt;
    logic [7:0] tx_sh_r;
    logic [7:0] rx;
    logic wb_we;
    logic [BI_W-1:0] wb_idx;
    logic frame_rst;

    // Deselect ends the frame at once, whatever byte was in flight
    assign frame_rst = LINK.slave_select_n | RST;

    always_comb begin
        rx = {fr_r.shreg, LINK.mosi};
        fr_nxt = fr_r;
        kp_nxt = kp_r;
        wb_we = 1'b0;
        wb_idx = kp_r.wr_cnt[BI_W-1:0];
        fr_nxt.bit_cnt = fr_r.bit_cnt + 3'h1;
        fr_nxt.shreg = rx[6:0];
        // A new frame forgets any write that was already committed
        if (fr_r.phase == smsp_pkg::PH_OPC && fr_r.bit_cnt == 3'h0) begin
            kp_nxt.wr_go = 1'b0;
        end
        if (fr_r.bit_cnt == smsp_pkg::LAST_BIT) begin
            fr_nxt.tx = smsp_pkg::IDLE_REPLY;
            case (fr_r.phase)
                smsp_pkg::PH_OPC: begin
                    fr_nxt.phase = smsp_pkg::PH_DATA;
                    fr_nxt.cmd = smsp_pkg::CMD_NONE;
                    if (rx == smsp_pkg::FETCH_OPCODE) begin
                        fr_nxt.cmd = smsp_pkg::CMD_FETCH;
                        fr_nxt.phase = smsp_pkg::PH_A2;
                    end else if (rx == smsp_pkg::PROGRAM_OPCODE && kp_r.armed) begin
                        fr_nxt.cmd = smsp_pkg::CMD_PROGRAM;
                        fr_nxt.phase = smsp_pkg::PH_A2;
                    end else if (rx == smsp_pkg::WRITE_ARM_OPCODE) begin
                        kp_nxt.armed = 1'b1;
                    end
                    // Any other opcode, a status one included, is ignored
                end
                smsp_pkg::PH_A2: begin
                    fr_nxt.ptr[23:16] = rx;
                    fr_nxt.phase = smsp_pkg::PH_A1;
                end
                smsp_pkg::PH_A1: begin
                    fr_nxt.ptr[15:8] = rx;
                    fr_nxt.phase = smsp_pkg::PH_A0;
                end
                smsp_pkg::PH_A0: begin
                    fr_nxt.phase = smsp_pkg::PH_DATA;
                    if (fr_r.cmd == smsp_pkg::CMD_FETCH) begin
                        fr_nxt.tx = mem_read({fr_r.ptr[23:8], rx});
                        fr_nxt.ptr = {fr_r.ptr[23:8], rx} + 24'h000001;
                    end else begin
                        kp_nxt.wr_addr = {fr_r.ptr[23:8], rx};
                        kp_nxt.wr_cnt = '0;
                        fr_nxt.ptr = {fr_r.ptr[23:8], rx};
                    end
                end
                smsp_pkg::PH_DATA: begin
                    if (fr_r.cmd == smsp_pkg::CMD_FETCH) begin
                        fr_nxt.tx = mem_read(fr_r.ptr);
                        fr_nxt.ptr = fr_r.ptr + 24'h000001;
                    end else if (fr_r.cmd == smsp_pkg::CMD_PROGRAM
                                 && kp_r.wr_cnt < DEPTH_C) begin
                        wb_we = 1'b1;
                        kp_nxt.wr_cnt = kp_r.wr_cnt + CNT_W'(1);
                        kp_nxt.wr_go = 1'b1;
                        kp_nxt.armed = 1'b0;
                        fr_nxt.ptr = fr_r.ptr + 24'h000001;
                    end
                end
                default: begin
                    fr_nxt.phase = smsp_pkg::PH_OPC;
                end
            endcase
        end
    end

    // Sample on the rising link clock edge
    always_ff @(posedge LINK.sck or posedge frame_rst) begin
        if (frame_rst) begin
            fr_r <= FRAME_RST;
        end else begin
            fr_r <= fr_nxt;
        end
    end

    // Arm flag and write descriptor outlive the frame
    always_ff @(posedge LINK.sck or posedge RST) begin
        if (RST) begin
            kp_r <= KEEP_RST;
        end else begin
            kp_r <= kp_nxt;
        end
    end

    always_ff @(posedge LINK.sck) begin
        if (wb_we) begin
            wbuf[wb_idx] <= rx;
        end
    end

    // Reply bits change on the falling edge; a finished byte loads the next
    always_ff @(negedge LINK.sck or posedge frame_rst) begin
        if (frame_rst) begin
            tx_sh_r <= smsp_pkg::IDLE_REPLY;
        end else if (fr_r.bit_cnt == 3'h0) begin
            tx_sh_r <= fr_r.tx;
        end else begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end
    end

    assign LINK.miso = tx_sh_r[7];

    // ****************************************************************
    // System domain: commit after deselect
    // ****************************************************************
    typedef enum {SY_IDLE, SY_PROG} smsp_sys_state_t;

    typedef struct packed {
        smsp_sys_state_t state;
        logic sel_prev;
        logic [CNT_W-1:0] idx;
        logic [CNT_W-1:0] n;
        logic [23:0] base;
        logic busy;
        logic done;
        logic armed;
        logic [7:0] peek;
    } smsp_sys_t;

    localparam smsp_sys_t SYS_RST = '{
        state: SY_IDLE, sel_prev: 1'b1, idx: '0, n: '0, base: 24'h000000,
        busy: 1'b0, done: 1'b0, armed: 1'b0, peek: 8'h00};

    smsp_sys_t sy_r;
    smsp_sys_t sy_nxt;
    logic sel_s;
    logic armed_s;
    logic mem_we;
    logic [23:0] mem_wa;
    logic [7:0] mem_wd;

    smsp_sync #(.W(2), .INIT(2'b01)) u_sync (
        .CLK(SYS_CLK),
        .RST(RST),
        .D({kp_r.armed, LINK.slave_select_n}),
        .Q({armed_s, sel_s})
    );

    always_comb begin
        sy_nxt = sy_r;
        sy_nxt.done = 1'b0;
        sy_nxt.sel_prev = sel_s;
        sy_nxt.armed = armed_s;
        sy_nxt.peek = mem_read(PEEK_ADDR);
        mem_we = 1'b0;
        mem_wa = sy_r.base + 24'(sy_r.idx);
        mem_wd = wbuf[sy_r.idx[BI_W-1:0]];
        case (sy_r.state)
            SY_IDLE: begin
                // Link side is frozen while select is high, so its fields are stable
                if (sel_s && !sy_r.sel_prev && kp_r.wr_go) begin
                    sy_nxt.state = SY_PROG;
                    sy_nxt.idx = '0;
                    sy_nxt.n = kp_r.wr_cnt;
                    sy_nxt.base = kp_r.wr_addr;
                    sy_nxt.busy = 1'b1;
                end
            end
            SY_PROG: begin
                mem_we = 1'b1;
                sy_nxt.idx = sy_r.idx + CNT_W'(1);
                if (sy_r.idx + CNT_W'(1) == sy_r.n) begin
                    sy_nxt.state = SY_IDLE;
                    sy_nxt.busy = 1'b0;
                    sy_nxt.done = 1'b1;
                end
            end
            default: begin
                sy_nxt.state = SY_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sy_r <= SYS_RST;
        end else begin
            sy_r <= sy_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (mem_we && smsp_pkg::in_range(mem_wa)) begin
            mem[smsp_pkg::mem_index(mem_wa)] <= mem_wd;
        end
    end

    assign PEEK_DATA = sy_r.peek;
    assign BUSY = sy_r.busy;
    assign PROG_DONE = sy_r.done;
    assign WRITE_ARMED = sy_r.armed;
endmodule

// file: rtl/smsp_master.sv
// Programming master end: divides its system clock into the link clock,
// frames one command per request and streams data bytes in and out.
// Assumes the slave answers on the falling link clock edge.
`timescale 1ns/10ps
module smsp_master #(
    parameter int HALF_CYC = smsp_pkg::SCK_HALF_CYC,
    parameter int GAP = smsp_pkg::GAP_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_OPCODE,
    input wire logic [23:0] CMD_ADDR,
    input wire logic [7:0] CMD_LEN,
    input wire logic [7:0] WR_DATA,
    output logic READY,
    output logic WD_TAKE,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    smsp_link_if.host LINK
);
    localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);
    localparam logic [7:0] GAP_C = 8'(GAP);
    localparam logic [7:0] MAXW = 8'(smsp_pkg::MAX_WRITE);

    typedef enum {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} smsp_host_state_t;

    typedef struct packed {
        smsp_host_state_t state;
        logic [7:0] tmr;
        logic [2:0] bits;
        logic [8:0] bidx;
        logic [8:0] total;
        logic [7:0] op;
        logic [23:0] addr;
        logic [7:0] tx;
        logic [7:0] rx;
        logic sck;
        logic ss_n;
        logic mosi;
        logic ready;
        logic take;
        logic rd_valid;
        logic [7:0] rd_data;
    } smsp_host_t;

    localparam smsp_host_t HOST_RST = '{
        state: H_IDLE, tmr: 8'h00, bits: 3'h0, bidx: 9'h000, total: 9'h000,
        op: 8'h00, addr: 24'h000000, tx: 8'h00, rx: 8'h00, sck: 1'b0,
        ss_n: 1'b1, mosi: 1'b0, ready: 1'b0, take: 1'b0, rd_valid: 1'b0,
        rd_data: 8'h00};

    smsp_host_t h_r;
    smsp_host_t h_nxt;
    logic miso_s;
    logic [8:0] nidx;
    logic [7:0] nbyte;
    logic [7:0] len;

    smsp_sync #(.W(1), .INIT(1'b0)) u_sync (
        .CLK(SYS_CLK),
        .RST(RST),
        .D(LINK.miso),
        .Q(miso_s)
    );

    // ****************************************************************
    // Byte sequencing
    // ****************************************************************
    function automatic logic [7:0] byte_at(input logic [8:0] i, input logic [7:0] op,
                                           input logic [23:0] a, input logic [7:0] wd);
        case (i)
            9'h001: byte_at = a[23:16];
            9'h002: byte_at = a[15:8];
            9'h003: byte_at = a[7:0];
            default: byte_at = (op == smsp_pkg::PROGRAM_OPCODE) ? wd : smsp_pkg::FILLER_BYTE;
        endcase
    endfunction

    always_comb begin
        h_nxt = h_r;
        h_nxt.take = 1'b0;
        h_nxt.rd_valid = 1'b0;
        nidx = h_r.bidx + 9'h001;
        nbyte = byte_at(nidx, h_r.op, h_r.addr, WR_DATA);
        len = (CMD_OPCODE == smsp_pkg::PROGRAM_OPCODE && CMD_LEN > MAXW) ? MAXW : CMD_LEN;
        case (h_r.state)
            H_IDLE: begin
                h_nxt.ready = 1'b1;
                if (CMD_VALID && h_r.ready) begin
                    h_nxt.ready = 1'b0;
                    h_nxt.op = CMD_OPCODE;
                    h_nxt.addr = CMD_ADDR;
                    h_nxt.total = (CMD_OPCODE == smsp_pkg::FETCH_OPCODE
                                   || CMD_OPCODE == smsp_pkg::PROGRAM_OPCODE)
                                  ? 9'h004 + 9'(len) : 9'h001;
                    h_nxt.ss_n = 1'b0;
                    h_nxt.tx = CMD_OPCODE;
                    h_nxt.mosi = CMD_OPCODE[7];
                    h_nxt.bits = 3'h0;
                    h_nxt.bidx = 9'h000;
                    h_nxt.tmr = HALF_M1;
                    h_nxt.state = H_LOW;
                end
            end
            H_LOW: begin
                h_nxt.tmr = h_r.tmr - 8'h01;
                if (h_r.tmr == 8'h00) begin
                    h_nxt.sck = 1'b1;
                    h_nxt.rx = {h_r.rx[6:0], miso_s};
                    h_nxt.tmr = HALF_M1;
                    h_nxt.state = H_HIGH;
                end
            end
            H_HIGH: begin
                h_nxt.tmr = h_r.tmr - 8'h01;
                if (h_r.tmr == 8'h00) begin
                    h_nxt.sck = 1'b0;
                    h_nxt.tmr = HALF_M1;
                    h_nxt.bits = h_r.bits + 3'h1;
                    h_nxt.state = H_LOW;
                    h_nxt.tx = {h_r.tx[6:0], 1'b0};
                    h_nxt.mosi = h_r.tx[6];
                    if (h_r.bits == smsp_pkg::LAST_BIT) begin
                        h_nxt.bidx = nidx;
                        if (h_r.op == smsp_pkg::FETCH_OPCODE && h_r.bidx >= 9'h004) begin
                            h_nxt.rd_valid = 1'b1;
                            h_nxt.rd_data = h_r.rx;
                        end
                        if (nidx == h_r.total) begin
                            h_nxt.mosi = 1'b0;
                            h_nxt.state = H_TAIL;
                        end else begin
                            h_nxt.tx = nbyte;
                            h_nxt.mosi = nbyte[7];
                            h_nxt.take = (h_r.op == smsp_pkg::PROGRAM_OPCODE
                                          && nidx >= 9'h004);
                        end
                    end
                end
            end
            H_TAIL: begin
                h_nxt.tmr = h_r.tmr - 8'h01;
                if (h_r.tmr == 8'h00) begin
                    h_nxt.ss_n = 1'b1;
                    h_nxt.tmr = GAP_C;
                    h_nxt.state = H_GAP;
                end
            end
            H_GAP: begin
                h_nxt.tmr = h_r.tmr - 8'h01;
                if (h_r.tmr == 8'h00) begin
                    h_nxt.state = H_IDLE;
                end
            end
            default: begin
                h_nxt.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            h_r <= HOST_RST;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign LINK.sck = h_r.sck;
    assign LINK.slave_select_n = h_r.ss_n;
    assign LINK.mosi = h_r.mosi;
    assign READY = h_r.ready;
    assign WD_TAKE = h_r.take;
    assign RD_DATA = h_r.rd_data;
    assign RD_VALID = h_r.rd_valid;
endmodule

// file: verif/smsp_link_properties.sv
// Checker on the serial link wires between the two ends.
// Assumes the master makes the link clock from SYS_CLK.
`timescale 1ns/10ps
module smsp_link_properties (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic sck,
    input wire logic slave_select_n,
    input wire logic mosi,
    input wire logic miso
);
    logic [2:0] bit_r;
    logic sck_d_r;
    // Counts link clock rises within a frame
    always_ff @(posedge SYS_CLK) begin
        sck_d_r <= sck;
        if (RST || slave_select_n) begin
            bit_r <= 3'h0;
        end else if (sck && !sck_d_r) begin
            bit_r <= bit_r + 3'h1;
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sck_idle_a: assert property (slave_select_n |-> !sck)
        else $error("link clock high while deselected");
    miso_idle_a: assert property (slave_select_n && $past(slave_select_n) |-> !miso)
        else $error("miso high while deselected");
    miso_edge_a: assert property (!slave_select_n && $changed(miso) |-> $fell(sck))
        else $error("miso changed away from a falling edge");
    mosi_hold_a: assert property (sck |-> $stable(mosi))
        else $error("mosi changed while clock high");
    sel_first_a: assert property ($rose(sck) |-> $past(slave_select_n, 2) == 1'b0)
        else $error("clock rose without select");
    sck_high_a: assert property ($rose(sck) |=> sck [*3] ##1 !sck)
        else $error("link clock high phase wrong");
    frame_bytes_a: assert property ($rose(slave_select_n) |-> bit_r == 3'h0)
        else $error("frame ended mid byte");
    frame_gap_a: assert property ($rose(slave_select_n) |=> slave_select_n [*8])
        else $error("frames too close");
    sel_hold_a: assert property (!slave_select_n && bit_r != 3'h0 |=> !slave_select_n)
        else $error("select released inside a byte");
endmodule

// file: verif/testbench.sv
// Bench joining master and slave over the link; commands go in at the master.
// Assumes one shared 25 MHz system clock for both ends.
`timescale 1ns/10ps
module testbench;
    logic SYS_CLK = 1'b0;
    logic RST = 1'b0;
    logic CMD_VALID = 1'b0;
    logic [7:0] CMD_OPCODE = 8'h00;
    logic [23:0] CMD_ADDR = 24'h000000;
    logic [7:0] CMD_LEN = 8'h00;
    logic [7:0] WR_DATA = 8'h00;
    logic [23:0] PEEK_ADDR = 24'h000000;
    logic READY, WD_TAKE, RD_VALID, BUSY, PROG_DONE, WRITE_ARMED;
    logic [7:0] RD_DATA, PEEK_DATA, mo, mi;
    logic [7:0] wbuf [0:129];
    logic [7:0] rq[$], mq[$], sq[$];
    logic [2:0] bc;
    int bad_count = 0;
    int num_checks = 0;
    int done_cnt = 0;
    int busy_cnt = 0;
    int widx = 0;
    smsp_link_if link();
    smsp_master i_smsp_master (.SYS_CLK(SYS_CLK), .RST(RST), .CMD_VALID(CMD_VALID),
        .CMD_OPCODE(CMD_OPCODE), .CMD_ADDR(CMD_ADDR), .CMD_LEN(CMD_LEN), .WR_DATA(WR_DATA),
        .READY(READY), .WD_TAKE(WD_TAKE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .LINK(link));
    smsp_slave i_smsp_slave (.LINK(link), .SYS_CLK(SYS_CLK), .RST(RST), .PEEK_ADDR(PEEK_ADDR),
        .PEEK_DATA(PEEK_DATA), .BUSY(BUSY), .PROG_DONE(PROG_DONE), .WRITE_ARMED(WRITE_ARMED));
    smsp_link_properties i_smsp_link_properties (.SYS_CLK(SYS_CLK), .RST(RST), .sck(link.sck),
        .slave_select_n(link.slave_select_n), .mosi(link.mosi), .miso(link.miso));
    always #20 SYS_CLK = ~SYS_CLK;
    // Collects read bytes and commits, feeds write bytes
    always @(posedge SYS_CLK) begin
        if (RD_VALID === 1'b1) rq.push_back(RD_DATA);
        if (PROG_DONE === 1'b1) done_cnt++;
        if (BUSY === 1'b1) busy_cnt++;
        if (WD_TAKE === 1'b1) #1 WR_DATA = wbuf[++widx];
    end
    // Decodes both data lines on the link clock, msb first
    always @(negedge link.slave_select_n) bc = 3'h0;
    always @(posedge link.sck) if (!link.slave_select_n) begin
        mo = {mo[6:0], link.mosi};
        mi = {mi[6:0], link.miso};
        bc++;
        if (bc == 3'h0) begin
            mq.push_back(mo);
            sq.push_back(mi);
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmpq(input string what, input logic [7:0] q[$], input logic [7:0] e[$]);
        chk({what, " count"}, 8'(e.size()), 8'(q.size()));
        foreach (e[i]) chk(what, e[i], q[i]);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] n);
        int k;
        rq.delete();
        mq.delete();
        sq.delete();
        widx = 0;
        busy_cnt = 0;
        WR_DATA = wbuf[0];
        CMD_OPCODE = op;
        CMD_ADDR = a;
        CMD_LEN = n;
        CMD_VALID = 1'b1;
        k = 0;
        do @(posedge SYS_CLK); while (READY !== 1'b1 && ++k < 1000);
        if (READY !== 1'b1) bad_count++;
        #1 CMD_VALID = 1'b0;
        repeat (3) @(posedge SYS_CLK);
        k = 0;
        while (READY !== 1'b1 && ++k < 20000) @(posedge SYS_CLK);
        if (READY !== 1'b1) bad_count++;
        #1;
    endtask
    task automatic peek(input logic [23:0] a, input logic [7:0] exp);
        PEEK_ADDR = a;
        repeat (2) @(posedge SYS_CLK);
        #1 chk("memory", exp, PEEK_DATA);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 80000);
        bad_count++;
        test_done;
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        #1 RST = 1'b1;
        repeat (5) @(posedge SYS_CLK);
        #1 RST = 1'b0;
        repeat (2) @(posedge SYS_CLK);
        #1 cmd(8'h06, 24'h000000, 8'h00);
        chk("armed", 8'h01, {7'h00, WRITE_ARMED});
        cmpq("arm reply", sq, '{8'h00});
        cmd(8'h01, 24'h000000, 8'h00);
        chk("armed", 8'h01, {7'h00, WRITE_ARMED});
        wbuf[0] = 8'ha5;
        wbuf[1] = 8'h5a;
        wbuf[2] = 8'hc3;
        cmd(8'h02, 24'h004000, 8'h03);
        chk("commits", 8'h01, done_cnt[7:0]);
        chk("busy cycles", 8'h03, busy_cnt[7:0]);
        chk("armed", 8'h00, {7'h00, WRITE_ARMED});
        cmpq("mosi", mq, '{8'h02, 8'h00, 8'h40, 8'h00, 8'ha5, 8'h5a, 8'hc3});
        cmpq("miso", sq, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        wbuf[0] = 8'h11;
        cmd(8'h02, 24'h004000, 8'h01);
        peek(24'h004000, 8'ha5);
        chk("commits", 8'h01, done_cnt[7:0]);
        chk("busy cycles", 8'h00, busy_cnt[7:0]);
        cmd(8'h03, 24'h004000, 8'h03);
        cmpq("read", rq, '{8'ha5, 8'h5a, 8'hc3});
        cmpq("miso", sq, '{8'h00, 8'h00, 8'h00, 8'h00, 8'ha5, 8'h5a, 8'hc3});
        wbuf[0] = 8'h3c;
        wbuf[1] = 8'h96;
        cmd(8'h06, 24'h000000, 8'h00);
        cmd(8'h02, 24'h0047ff, 8'h02);
        cmd(8'h03, 24'h0047ff, 8'h02);
        cmpq("edge read", rq, '{8'h3c, 8'h00});
        wbuf[0] = 8'h77;
        cmd(8'h06, 24'h000000, 8'h00);
        cmd(8'h02, 24'h008080, 8'h01);
        for (int i = 0; i < 130; i++) wbuf[i] = 8'(i);
        cmd(8'h06, 24'h000000, 8'h00);
        cmd(8'h02, 24'h008000, 8'h81);
        chk("busy cycles", 8'h80, busy_cnt[7:0]);
        peek(24'h00807f, 8'h7f);
        peek(24'h008080, 8'h77);
        wbuf[0] = 8'he1;
        cmd(8'h06, 24'h000000, 8'h00);
        cmd(8'h02, 24'h027fff, 8'h01);
        peek(24'h027fff, 8'he1);
        test_done;
    end
endmodule
